// File: src/tracking_defines.vh
// Constants for the resolver tracking loop: register map, fields, resets, timing
`ifndef TRACKING_DEFINES_VH
`define TRACKING_DEFINES_VH

// Register byte addresses
`define ADR_FRONTEND     8'h00
`define ADR_LOOP         8'h04
`define ADR_STATUS       8'h08
`define ADR_ANGLE        8'h0C
`define ADR_VELOCITY     8'h10

// Front-end config fields and reset
`define SIN_GAIN_LSB     0
`define COS_GAIN_LSB     4
`define GAIN_MAX         4'hB
`define FRONTEND_RST     8'h44

// Loop config fields and reset
`define ACCEL_LSB        0
`define BOOST_LSB        3
`define INTEG_LSB        6
`define LOOP_RST         9'h113

// Status bit positions
`define ST_UNSTABLE      0
`define ST_BOOST         1
`define ST_EXC_FAULT     2
`define ST_RES12         3
`define ST_STABLE        4

// Loop arithmetic
`define ACC_W            24
`define KI_BASE          4'hA
`define IIR_SHIFT        12
`define STABLE_CNT       4'h8
`define ACCEL_RUN        5'h10

// Timing
`define CLK_MHZ          250
`define LOOP_DIV         5'h10
`define EXC_TIMEOUT_US   200
`define EXC_TIMEOUT_CYC  (`EXC_TIMEOUT_US * `CLK_MHZ)

`endif

// File: src/sincos_table.v
// Quarter-wave sine and cosine table with registered 10-bit DAC codes
`timescale 1ns/1ps
module sincos_table (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Angle index, 128 steps per turn
  input  wire [6:0] angle_idx,
  // DAC codes, offset binary
  output reg  [9:0] sine_code,
  output reg  [9:0] cosine_code
);

  // Quarter-wave amplitude, 0..32 maps 0..90 degrees
  function [8:0] quarter;
    input [5:0] i;
    begin
      case (i)
        6'h00: quarter = 9'h000;  6'h01: quarter = 9'h019;
        6'h02: quarter = 9'h032;  6'h03: quarter = 9'h04B;
        6'h04: quarter = 9'h064;  6'h05: quarter = 9'h07C;
        6'h06: quarter = 9'h094;  6'h07: quarter = 9'h0AC;
        6'h08: quarter = 9'h0C4;  6'h09: quarter = 9'h0DA;
        6'h0A: quarter = 9'h0F1;  6'h0B: quarter = 9'h107;
        6'h0C: quarter = 9'h11C;  6'h0D: quarter = 9'h130;
        6'h0E: quarter = 9'h144;  6'h0F: quarter = 9'h157;
        6'h10: quarter = 9'h169;  6'h11: quarter = 9'h17B;
        6'h12: quarter = 9'h18B;  6'h13: quarter = 9'h19A;
        6'h14: quarter = 9'h1A9;  6'h15: quarter = 9'h1B6;
        6'h16: quarter = 9'h1C3;  6'h17: quarter = 9'h1CE;
        6'h18: quarter = 9'h1D8;  6'h19: quarter = 9'h1E1;
        6'h1A: quarter = 9'h1E9;  6'h1B: quarter = 9'h1F0;
        6'h1C: quarter = 9'h1F5;  6'h1D: quarter = 9'h1F9;
        6'h1E: quarter = 9'h1FD;  6'h1F: quarter = 9'h1FE;
        default: quarter = 9'h1FF;
      endcase
    end
  endfunction

  // Full-wave value folded from the quarter table
  function [9:0] wave;
    input [6:0] a;
    reg   [8:0] v;
    begin
      v    = quarter(a[5] ? (6'h20 - {1'b0, a[4:0]}) : {1'b0, a[4:0]});
      wave = a[6] ? (10'h200 - {1'b0, v}) : (10'h200 + {1'b0, v});
    end
  endfunction

  // Cosine is the sine a quarter turn ahead
  wire [6:0] cos_idx = angle_idx + 7'h20;

  // Registered read, codes rest mid-scale in reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sine_code   <= 10'h200;
      cosine_code <= 10'h200;
    end else begin
      sine_code   <= wave(angle_idx);
      cosine_code <= wave(cos_idx);
    end
  end

endmodule // sincos_table

// File: src/resolver_tracking_loop.v
// Digital tracking loop with boost control, exciter monitor and Wishbone registers
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tracking_defines.vh"
module resolver_tracking_loop #(
  parameter EXC_TIMEOUT = `EXC_TIMEOUT_CYC  // Exciter edge watchdog, cycles
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Comparator and exciter feedback levels
  input  wire        error_pulse,
  input  wire        deviation_out_of_limits,
  input  wire        exciter_feedback_pos,
  input  wire        exciter_feedback_neg,
  // Mode pins
  input  wire        accel_select_pin,
  input  wire        resolution_select_pin,
  // Front-end gain settings
  output reg  [3:0]  sine_channel_gain,
  output reg  [3:0]  cosine_channel_gain,
  // Feedback DAC codes
  output wire [9:0]  sine_dac,
  output wire [9:0]  cosine_dac,
  // Results and diagnostics
  output reg  [11:0] parallel_out,
  output reg  [11:0] velocity_out,
  output reg         loop_unstable_flag,
  output reg         boost_active,
  output reg         exciter_ref_pulse,
  output reg         exciter_fault
);

  // Boost controller states
  localparam [1:0] ST_NORMAL  = 2'b00;  // Accel factor only
  localparam [1:0] ST_BOOST   = 2'b01;  // Accel factor plus boost
  localparam [1:0] ST_SETTLED = 2'b10;  // Boost parked until next event

  // Configuration registers
  reg  [7:0]  frontend_config_reg;
  reg  [8:0]  loop_config_reg;
  // Loop state
  reg  [`ACC_W-1:0] angle_reg;          // Angle accumulator
  reg  [`ACC_W-1:0] integ_reg;          // Integral path, two's complement
  reg  signed [35:0] filt_reg;          // Velocity filter state
  reg  [11:0] held_angle_reg;           // Angle presented at the outputs
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [4:0]  div_reg;                  // Loop rate divider
  reg         tick_reg;                 // Loop update enable
  reg         last_sign_reg;            // Error sign at previous tick
  reg  [3:0]  toggle_cnt_reg;           // Run of alternating signs
  reg  [4:0]  same_cnt_reg;             // Run of equal signs
  // Exciter monitor
  reg         exc_pos_d_reg;
  reg         exc_phase_reg;
  reg  [31:0] exc_wd_reg;

  // Configuration fields
  wire [2:0] accel_factor         = loop_config_reg[`ACCEL_LSB +: 3];
  wire [2:0] boost_multiplier     = loop_config_reg[`BOOST_LSB +: 3];
  wire [2:0] integration_constant = loop_config_reg[`INTEG_LSB +: 3];
  wire [3:0] sin_field            = frontend_config_reg[`SIN_GAIN_LSB +: 4];
  wire [3:0] cos_field            = frontend_config_reg[`COS_GAIN_LSB +: 4];

  // Bus request decode
  wire bus_req  = wb_cyc_i & wb_stb_i;
  wire bus_wr   = bus_req & wb_we_i & wb_ack_o;
  wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};

  // Stability judgement on the error pulse
  wire loop_stable = (toggle_cnt_reg >= `STABLE_CNT);
  wire accel_event = (same_cnt_reg >= `ACCEL_RUN);

  // Error sign demodulated against the exciter phase reference
  wire err_sign = error_pulse ^ exc_phase_reg;

  // Proportional gain: boost shift only while boosting
  wire [3:0] kp_shift = {1'b0, accel_factor} +
                        ((state_reg == ST_BOOST) ? {1'b0, boost_multiplier} : 4'h0);
  wire [`ACC_W-1:0] prop_mag  = {{(`ACC_W-1){1'b0}}, 1'b1} << kp_shift;
  wire [`ACC_W-1:0] prop_term = err_sign ? (~prop_mag + 1'b1) : prop_mag;

  // Integral step shrinks as the integration constant grows
  wire [3:0] ki_shift = `KI_BASE - {1'b0, integration_constant};
  wire [`ACC_W-1:0] integ_mag = {{(`ACC_W-1){1'b0}}, 1'b1} << ki_shift;
  wire [`ACC_W:0] integ_sum = err_sign ?
         ({integ_reg[`ACC_W-1], integ_reg} - {1'b0, integ_mag}) :
         ({integ_reg[`ACC_W-1], integ_reg} + {1'b0, integ_mag});
  // Saturate rather than wrap, so velocity cannot flip sign at high speed
  wire integ_ovf = integ_sum[`ACC_W] ^ integ_sum[`ACC_W-1];
  wire [`ACC_W-1:0] integ_next = integ_ovf ?
         (integ_sum[`ACC_W] ? {1'b1, {(`ACC_W-1){1'b0}}} : {1'b0, {(`ACC_W-1){1'b1}}}) :
         integ_sum[`ACC_W-1:0];

  // Angle accumulates velocity plus proportional kick, wrapping per turn
  wire [`ACC_W-1:0] angle_next = angle_reg + integ_reg + prop_term;

  // First-order IIR on velocity, alpha of one part in 4096 per clock
  wire signed [35:0] iir_in   = $signed({integ_reg, 12'h000});
  wire signed [35:0] iir_diff = iir_in - filt_reg;
  wire signed [35:0] iir_next = filt_reg + (iir_diff >>> `IIR_SHIFT);
  wire [11:0] vel12 = filt_reg[35:24];

  // Exciter watchdog limit held at counter width
  wire [31:0] exc_limit = EXC_TIMEOUT;

  // Loop rate divider: one-cycle enable every LOOP_DIV clocks
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == `LOOP_DIV - 5'h01) begin
      div_reg  <= 5'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 5'h01;
      tick_reg <= 1'b0;
    end
  end

  // Exciter monitor: phase reference, edge pulse and watchdog
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exc_pos_d_reg     <= 1'b0;
      exc_phase_reg     <= 1'b0;
      exc_wd_reg        <= 32'h0000_0000;
      exciter_ref_pulse <= 1'b0;
      exciter_fault     <= 1'b0;
    end else begin
      exc_pos_d_reg     <= exciter_feedback_pos;
      // Phase is positive half-wave of the differential feedback
      exc_phase_reg     <= exciter_feedback_pos & ~exciter_feedback_neg;
      // Reference pulse on each rising edge of the positive leg
      exciter_ref_pulse <= exciter_feedback_pos & ~exc_pos_d_reg;
      if (exciter_feedback_pos & ~exc_pos_d_reg) begin
        exc_wd_reg <= 32'h0000_0000;
      end else if (exc_wd_reg != exc_limit) begin
        exc_wd_reg <= exc_wd_reg + 32'h0000_0001;
      end
      // Fault on missing edges or both legs high together
      exciter_fault <= (exc_wd_reg == exc_limit) |
                       (exciter_feedback_pos & exciter_feedback_neg);
    end
  end

  // Boost controller next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        if (accel_select_pin) begin
          state_next = ST_BOOST;
        end
      end
      ST_BOOST: begin
        if (!accel_select_pin) begin
          state_next = ST_NORMAL;
        end else if (loop_stable & ~loop_unstable_flag) begin
          state_next = ST_SETTLED;
        end
      end
      ST_SETTLED: begin
        if (!accel_select_pin) begin
          state_next = ST_NORMAL;
        end else if (accel_event | loop_unstable_flag) begin
          state_next = ST_BOOST;
        end
      end
      default: begin
        state_next = ST_NORMAL;
      end
    endcase
  end

  // Tracking loop core, advanced on the loop tick
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      angle_reg      <= {`ACC_W{1'b0}};
      integ_reg      <= {`ACC_W{1'b0}};
      state_reg      <= ST_NORMAL;
      last_sign_reg  <= 1'b0;
      toggle_cnt_reg <= 4'h0;
      same_cnt_reg   <= 5'h00;
      held_angle_reg <= 12'h000;
    end else if (tick_reg) begin
      angle_reg     <= angle_next;
      integ_reg     <= integ_next;
      state_reg     <= state_next;
      last_sign_reg <= err_sign;
      // Alternating signs mean the loop dithers around the true angle
      if (err_sign != last_sign_reg) begin
        same_cnt_reg <= 5'h00;
        if (toggle_cnt_reg != `STABLE_CNT) begin
          toggle_cnt_reg <= toggle_cnt_reg + 4'h1;
        end
      end else begin
        toggle_cnt_reg <= 4'h0;
        if (same_cnt_reg != `ACCEL_RUN) begin
          same_cnt_reg <= same_cnt_reg + 5'h01;
        end
      end
      // Output angle is frozen while boosting, then jumps to the new value
      if (state_reg != ST_BOOST) begin
        held_angle_reg <= angle_reg[`ACC_W-1 -: 12];
      end
    end
  end

  // Velocity filter runs at the full clock rate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_reg <= 36'sh0_0000_0000;
    end else begin
      filt_reg <= iir_next;
    end
  end

  // Result formatting per the resolution pin, plus diagnostics
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parallel_out       <= 12'h000;
      velocity_out       <= 12'h000;
      loop_unstable_flag <= 1'b0;
      boost_active       <= 1'b0;
      sine_channel_gain  <= 4'h4;
      cosine_channel_gain <= 4'h4;
    end else begin
      if (resolution_select_pin) begin
        parallel_out <= held_angle_reg;
        velocity_out <= vel12;
      end else begin
        parallel_out <= {2'b00, held_angle_reg[11:2]};
        velocity_out <= {{2{vel12[11]}}, vel12[11:2]};
      end
      // Window comparator level taken as the instability indication
      loop_unstable_flag <= deviation_out_of_limits;
      boost_active       <= (state_reg == ST_BOOST);
      // Gain codes 0..11 map 0.75 to 3.5 in steps of 0.25
      sine_channel_gain   <= (sin_field > `GAIN_MAX) ? `GAIN_MAX : sin_field;
      cosine_channel_gain <= (cos_field > `GAIN_MAX) ? `GAIN_MAX : cos_field;
    end
  end

  // Wishbone slave: ack one cycle after the request, write on the ack edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h0000_0000;
      frontend_config_reg <= `FRONTEND_RST;
      loop_config_reg     <= `LOOP_RST;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      // Read data latched as ack rises, held while ack stands
      if (bus_req & ~wb_ack_o) begin
        if (word_adr == `ADR_FRONTEND) begin
          wb_dat_o <= {24'h000000, frontend_config_reg};
        end else if (word_adr == `ADR_LOOP) begin
          wb_dat_o <= {23'h000000, loop_config_reg};
        end else if (word_adr == `ADR_STATUS) begin
          wb_dat_o <= {27'h0000000, loop_stable, resolution_select_pin,
                       exciter_fault, boost_active, loop_unstable_flag};
        end else if (word_adr == `ADR_ANGLE) begin
          wb_dat_o <= {20'h00000, parallel_out};
        end else if (word_adr == `ADR_VELOCITY) begin
          wb_dat_o <= {20'h00000, velocity_out};
        end else begin
          wb_dat_o <= 32'h0000_0000;  // Unmapped reads as zero
        end
      end
      // Writes honour byte lanes; read-only words ignore writes
      if (bus_wr) begin
        if (word_adr == `ADR_FRONTEND) begin
          if (wb_sel_i[0]) begin
            frontend_config_reg <= wb_dat_i[7:0];
          end
        end else if (word_adr == `ADR_LOOP) begin
          if (wb_sel_i[0]) begin
            loop_config_reg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            loop_config_reg[8] <= wb_dat_i[8];
          end
        end
      end
    end
  end

  // Feedback tables: the analog multiplier forms the product difference from these codes
  sincos_table u_table (
    .clk         (clk),
    .rst_b       (rst_b),
    .angle_idx   (angle_reg[`ACC_W-1 -: 7]),
    .sine_code   (sine_dac),
    .cosine_code (cosine_dac)
  );

endmodule // resolver_tracking_loop

// File: sim/tracking_loop_monitor.sv
// Port checker for the resolver tracking loop
`timescale 1ns/1ps
`include "tracking_defines.vh"
module tracking_loop_monitor (
  // Clock and reset
  input wire        clk,
  input wire        rst_b,
  // Bus and pins
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        deviation_out_of_limits,
  input wire        exciter_feedback_pos,
  input wire        exciter_feedback_neg,
  input wire        accel_select_pin,
  input wire        resolution_select_pin,
  // Watched outputs
  input wire [3:0]  sine_channel_gain,
  input wire [3:0]  cosine_channel_gain,
  input wire [11:0] parallel_out,
  input wire [11:0] velocity_out,
  input wire        loop_unstable_flag,
  input wire        boost_active,
  input wire        exciter_ref_pulse,
  input wire        exciter_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("bus request not answered");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_dat_hold; wb_ack_o |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved after ack");
  property p_gain_clamp; sine_channel_gain <= `GAIN_MAX && cosine_channel_gain <= `GAIN_MAX; endproperty
  a_gain_clamp: assert property (p_gain_clamp) else $error("gain code beyond top step");
  property p_unstable_set; deviation_out_of_limits |=> loop_unstable_flag; endproperty
  a_unstable_set: assert property (p_unstable_set) else $error("unstable flag missed");
  property p_unstable_clr; !deviation_out_of_limits |=> !loop_unstable_flag; endproperty
  a_unstable_clr: assert property (p_unstable_clr) else $error("unstable flag stuck");
  property p_res10_out; !resolution_select_pin |=> parallel_out[11:10] == 2'h0; endproperty
  a_res10_out: assert property (p_res10_out) else $error("angle above ten bits");
  property p_res10_vel; !resolution_select_pin |=> velocity_out[11:10] == {2{velocity_out[9]}}; endproperty
  a_res10_vel: assert property (p_res10_vel) else $error("velocity not ten bits");
  property p_boost_off; !accel_select_pin [*8] ##1 !accel_select_pin [*8] ##1
    !accel_select_pin [*2] |-> !boost_active; endproperty
  a_boost_off: assert property (p_boost_off) else $error("boost while pin low");
  property p_boost_on; $rose(accel_select_pin) |-> ##[1:40] boost_active; endproperty
  a_boost_on: assert property (p_boost_on) else $error("boost not engaged");
  property p_frozen; (boost_active && $stable(resolution_select_pin)) [*4] |-> $stable(parallel_out); endproperty
  a_frozen: assert property (p_frozen) else $error("angle moved during boost");
  property p_ref_once; exciter_ref_pulse |=> !exciter_ref_pulse; endproperty
  a_ref_once: assert property (p_ref_once) else $error("reference pulse too long");
  property p_ref_rise; $rose(exciter_feedback_pos) && !exciter_feedback_neg |-> ##[1:4] exciter_ref_pulse; endproperty
  a_ref_rise: assert property (p_ref_rise) else $error("reference pulse missing");
  property p_legs; (exciter_feedback_pos && exciter_feedback_neg) [*2] |-> ##[0:4] exciter_fault; endproperty
  a_legs: assert property (p_legs) else $error("both legs high without fault");
endmodule // tracking_loop_monitor

bind resolver_tracking_loop tracking_loop_monitor tracking_loop_monitor_inst (.*);

// File: sim/resolver_frontend_model.sv
// Behavioural resolver front end: comparator error bit and exciter feedback legs
`timescale 1ns/1ps
module resolver_frontend_model (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Error 0 toggles, 1 high, 2 low; exciter 0 off, 1 running, 2 both legs high
  input  wire [1:0] err_mode,
  input  wire [1:0] exc_mode,
  // Levels towards the loop
  output reg        error_pulse,
  output reg        exciter_feedback_pos,
  output reg        exciter_feedback_neg
);
  reg [5:0] div_reg; // Free divider, 64 clocks per exciter period

  // Levels change only at clock edges, like a clocked comparator
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg              <= 6'h00;
      error_pulse          <= 1'b0;
      exciter_feedback_pos <= 1'b0;
      exciter_feedback_neg <= 1'b0;
    end else begin
      div_reg <= div_reg + 6'h01;
      // Toggle once per 16 clocks so each loop tick sees the opposite sign
      if (err_mode == 2'h0) begin
        if (div_reg[3:0] == 4'hF) begin
          error_pulse <= ~error_pulse;
        end
      end else begin
        error_pulse <= (err_mode == 2'h1);
      end
      // A stopped exciter leaves both legs low, never at a stale level
      exciter_feedback_pos <= (exc_mode == 2'h2) | ((exc_mode == 2'h1) & div_reg[5]);
      exciter_feedback_neg <= (exc_mode == 2'h2) | ((exc_mode == 2'h1) & ~div_reg[5]);
    end
  end
endmodule // resolver_frontend_model

// File: sim/tb_top.sv
// Self-checking bench for the resolver tracking loop
`timescale 1ns/1ps
`include "tracking_defines.vh"
module tb_top;
  typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;} row_t;
  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;        // Clock, reset, bus strobes
  logic [7:0]  wb_adr_i;                                                  // Bus address
  logic [3:0]  wb_sel_i, sine_channel_gain, cosine_channel_gain;          // Lanes and gain codes
  logic [31:0] wb_dat_i, wb_dat_o, rd;                                    // Bus data, last read
  logic        error_pulse, deviation_out_of_limits, pos, neg;            // Front end levels
  logic        accel_select_pin, resolution_select_pin;                  // Mode pins
  logic [9:0]  sine_dac, cosine_dac;                                      // Feedback codes
  logic [11:0] parallel_out, velocity_out;                                // Results
  logic        loop_unstable_flag, boost_active, exciter_ref_pulse, exciter_fault;
  logic [1:0]  err_mode, exc_mode;                                        // Model commands
  integer      failures, comparisons, n, k, maxp, wraps;
  // Ordinary register traffic: writes, lane writes, read-only and unmapped places
  row_t rows [0:11] = '{'{1, `ADR_FRONTEND, 4'hF, 32'h5A}, '{0, `ADR_FRONTEND, 4'hF, 32'h5A},
    '{1, `ADR_LOOP, 4'hF, 32'h1A5}, '{0, `ADR_LOOP, 4'hF, 32'h1A5}, '{1, `ADR_LOOP, 4'h1, 32'hFF},
    '{0, `ADR_LOOP, 4'hF, 32'h1FF}, '{1, `ADR_LOOP, 4'h2, 32'h0}, '{0, `ADR_LOOP, 4'hF, 32'hFF},
    '{1, `ADR_ANGLE, 4'hF, 32'hFFF}, '{1, 8'h14, 4'hF, 32'h77}, '{0, 8'h14, 4'hF, 32'h0},
    '{0, `ADR_FRONTEND, 4'hF, 32'h5A}};

  resolver_tracking_loop #(.EXC_TIMEOUT(200)) resolver_tracking_loop_inst (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .error_pulse(error_pulse),
    .deviation_out_of_limits(deviation_out_of_limits), .exciter_feedback_pos(pos), .exciter_feedback_neg(neg),
    .accel_select_pin(accel_select_pin), .resolution_select_pin(resolution_select_pin),
    .sine_channel_gain(sine_channel_gain), .cosine_channel_gain(cosine_channel_gain), .sine_dac(sine_dac),
    .cosine_dac(cosine_dac), .parallel_out(parallel_out), .velocity_out(velocity_out),
    .loop_unstable_flag(loop_unstable_flag), .boost_active(boost_active),
    .exciter_ref_pulse(exciter_ref_pulse), .exciter_fault(exciter_fault));
  resolver_frontend_model resolver_frontend_model_inst (.clk(clk), .rst_b(rst_b), .err_mode(err_mode),
    .exc_mode(exc_mode), .error_pulse(error_pulse), .exciter_feedback_pos(pos), .exciter_feedback_neg(neg));

  // Case equality so an unknown never passes
  task chk(input [63:0] got, input [63:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
    end
  endtask

  // Classic cycle: hold all until ack is sampled, then release
  task wb(input logic we, input [7:0] adr, input [3:0] sel, input [31:0] dat);
    begin
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      rd = wb_dat_o;
      chk(n < 20, 1, "bus answer");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // Bounded wait for a boost level
  task wait_boost(input logic lvl, input integer lim);
    begin
      k = 0;
      while (boost_active !== lvl && k < lim) begin
        @(posedge clk);
        k = k + 1;
      end
    end
  endtask

  // Free tracking run: angle span and wraps, velocity slew, DAC circle
  task track(input logic res, input integer cyc);
    integer i, s, c, dv;
    logic [11:0] lp, lv;
    begin
      resolution_select_pin <= res;
      repeat (4) @(posedge clk);
      maxp = 0;
      wraps = 0;
      lp = parallel_out;
      lv = velocity_out;
      chk(loop_unstable_flag, 0, "data valid");
      for (i = 0; i < cyc; i = i + 1) begin
        @(posedge clk);
        dv = int'($signed(velocity_out)) - int'($signed(lv));
        if (dv > 1 || dv < -1) chk(velocity_out, lv, "velocity slew");
        if (parallel_out > maxp) maxp = parallel_out;
        s = int'(parallel_out) - int'(lp);
        if (s > (res ? 2048 : 512) || s < (res ? -2048 : -512)) wraps = wraps + 1;
        s = int'(sine_dac) - 512;
        c = int'(cosine_dac) - 512;
        if (s * s + c * c < 160000 || s * s + c * c > 280900) chk(s * s + c * c, 261121, "dac circle");
        lp = parallel_out;
        lv = velocity_out;
      end
      chk(wraps > 0, 1, "angle wrap");
      chk(res ? maxp > 12'h3FF : maxp >= 12'h300 && maxp <= 12'h3FF, 1, "angle span");
      chk(velocity_out != 12'h0, 1, "velocity");
      $display("test track %0d done", res);
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is near 22000 cycles; cut off at 60000
  initial begin
    #240000;
    failures = failures + 1;
    conclude;
  end

  initial begin
    {failures, comparisons} = 0;
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
    {deviation_out_of_limits, accel_select_pin, exc_mode} = 0;
    resolution_select_pin = 1'b1;
    err_mode = 2'h1;
    repeat (5) @(posedge clk);
    chk({wb_ack_o, sine_channel_gain, cosine_channel_gain, sine_dac, cosine_dac, parallel_out},
        {1'b0, 4'h4, 4'h4, 10'h200, 10'h200, 12'h0}, "reset outputs");
    rst_b <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk({sine_dac, cosine_dac}, {10'h200, 10'h3FF}, "wave start");
    for (int r = 0; r < 12; r++) begin
      wb(rows[r].we, rows[r].adr, rows[r].sel, rows[r].dat);
      if (!rows[r].we) chk(rd & (rows[r].adr == 8'h14 ? 32'hFFFFFFFF : 32'h1FF), rows[r].dat, "reg read");
      if (rows[r].we && rows[r].adr == `ADR_FRONTEND)
        chk({cosine_channel_gain, sine_channel_gain}, rows[r].dat[7:0], "gain ports");
    end
    wb(1, `ADR_FRONTEND, 4'hF, 32'hFC);
    chk({cosine_channel_gain, sine_channel_gain}, 8'hBB, "gain clamp");
    wb(1, `ADR_FRONTEND, 4'hF, 32'hB0);
    chk({cosine_channel_gain, sine_channel_gain}, 8'hB0, "gain split");
    wb(1, `ADR_LOOP, 4'hF, {23'h0, `LOOP_RST});
    $display("test registers done");
    track(1'b1, 16000);
    track(1'b0, 4000);
    accel_select_pin <= 1'b1;
    wait_boost(1'b1, 40);
    chk(boost_active, 1, "boost on");
    wb(0, `ADR_STATUS, 4'hF, 32'h0);
    chk(rd & 32'hB, 32'h2, "status boost");
    err_mode <= 2'h0;
    wait_boost(1'b0, 250);
    chk(k >= 100 && k < 250, 1, "settle time");
    err_mode <= 2'h1;
    wait_boost(1'b1, 340);
    chk(k >= 200 && k < 340, 1, "accel event");
    err_mode <= 2'h0;
    wait_boost(1'b0, 250);
    chk(boost_active, 0, "settle again");
    deviation_out_of_limits <= 1'b1;
    wait_boost(1'b1, 40);
    chk({boost_active, loop_unstable_flag}, 2'h3, "instability");
    wb(0, `ADR_STATUS, 4'hF, 32'h0);
    chk(rd & 32'h3, 32'h3, "status unstable");
    deviation_out_of_limits <= 1'b0;
    accel_select_pin <= 1'b0;
    wait_boost(1'b0, 20);
    chk(boost_active, 0, "normal mode");
    $display("test accel done");
    exc_mode <= 2'h1;
    repeat (200) @(posedge clk);
    chk(exciter_fault, 0, "exciter running");
    n = 0;
    repeat (640) begin
      @(posedge clk);
      if (exciter_ref_pulse === 1'b1) n = n + 1;
    end
    chk(n, 10, "reference pulses");
    exc_mode <= 2'h2;
    repeat (8) @(posedge clk);
    chk(exciter_fault, 1, "legs shorted");
    exc_mode <= 2'h0;
    repeat (40) @(posedge clk);
    chk(exciter_fault, 0, "watchdog early");
    repeat (250) @(posedge clk);
    chk(exciter_fault, 1, "watchdog expiry");
    $display("test exciter done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({sine_channel_gain, cosine_channel_gain, exciter_fault}, 9'h88, "second reset");
    rst_b <= 1'b1;
    @(posedge clk);
    wb(0, `ADR_LOOP, 4'hF, 32'h0);
    chk(rd & 32'h1FF, `LOOP_RST, "loop reset value");
    wb(0, `ADR_FRONTEND, 4'hF, 32'h0);
    chk(rd & 32'hFF, `FRONTEND_RST, "frontend reset value");
    $display("test reset done");
    conclude;
  end
endmodule // tb_top
